// ===== pkg/ehb_map.svh
// Purpose: Constants of the memory-port bus hold handshake.
// Assumes: All delays are counted in memory-port clock periods (E).
// Notes:   Tick counts include one extra tick for the unknown phase of the first tick.
`ifndef EHB_MAP_SVH
`define EHB_MAP_SVH

// Handshake delays in memory-port clock periods
`define EHB_FLOAT_MIN_E   3'd2
`define EHB_RESUME_MIN_E  3'd2
`define EHB_RESUME_MAX_E  3'd7

// Ticks to wait: the first tick may come at once, so one more is counted
`define EHB_FLOAT_TICKS   (`EHB_FLOAT_MIN_E + 3'd1)
`define EHB_RESUME_TICKS  (`EHB_RESUME_MIN_E + 3'd1)
`define EHB_TICK_SAT      3'd7

// Core clock dividers for the memory-port clock (last count of each)
`define EHB_DIV4_LAST     3'd3
`define EHB_DIV6_LAST     3'd5

// Memory-port clock source select codes
`define EHB_SRC_EXT       2'h0
`define EHB_SRC_DIV4      2'h1
`define EHB_SRC_DIV6      2'h2

`endif

// ===== pkg/ehb_pkg.sv
// Purpose: Types of the memory-port bus hold handshake.
// Assumes: Nothing beyond ehb_map.svh.
// Notes:   Output enables are active low (0 = pin driven).
package ehb_pkg;

    typedef enum logic [2:0] {
        EHB_IDLE   = 3'h0,
        EHB_DRAIN  = 3'h1,
        EHB_FLOAT  = 3'h3,
        EHB_HELD   = 3'h2,
        EHB_RESUME = 3'h6,
        EHB_UNACK  = 3'h7
    } ehb_state_e;

    typedef struct packed {
        logic chip_en_oe_n;
        logic byte_en_oe_n;
        logic data_oe_n;
        logic addr_oe_n;
        logic strobe_oe_n;
        logic sdram_clock_enable_oe_n;
        logic extra_output_enable_oe_n;
        logic peripheral_transfer_strobe_oe_n;
    } ehb_pin_oe_s;

endpackage

// ===== rtl/ehb_sync.sv
// Purpose: Two-stage synchroniser for one level.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps

module ehb_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_i,     // Clock
    input  wire logic rst_n_i,   // Sync reset, active low
    input  wire logic d_i,       // Asynchronous level
    output logic      q_o        // Synchronised level
);

    logic meta;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= RESET_VAL;
            q_o  <= RESET_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

// ===== rtl/ehb_top.sv
// Purpose: Bus hold handshake for the external memory port (wide or narrow).
// Assumes: 250 MHz clk_i; memory-port clock is a tick enable from a divider or ext clock edge.
// Notes:   All pin enables are active low; the pins themselves live in the memory controller.
`timescale 1ns/1ps
`include "ehb_map.svh"

// Function
// RULE1: Float port pins no sooner than two port clocks after request falls.
// RULE2: Drive acknowledge low within two port clocks after pins float.
// RULE3: Requester keeps request low one port clock after acknowledge falls.
// RULE4: Drive pins again two to seven port clocks after request rises.
// RULE5: Raise acknowledge within two port clocks after pins are driven.
// RULE6: With clock float chosen, float clock output at least two port clocks late.
// RULE7: Drive floated clock output again two to seven port clocks after release.
// RULE8: With float select 0, clock output keeps toggling while released.
// RULE9: With float select 1, clock output floats while released.
// RULE10: Finish pending transactions before acknowledging; idle bus gives minimum delay.
// RULE11: While release block is set, never grant the bus. The code checks the block only in EHB_DRAIN, not in EHB_FLOAT.
// RULE12: Wide port releases enables, data, address, strobes, clock enable, extras.
// RULE13: Narrow port releases the same set without the clock enable.
// RULE14: Count delays in port clock periods: external clock, core/4 or core/6.
// RULE15: Synchronise the request through two stages before use.
// RULE16: Hold acknowledge low and start nothing while request stays low.
module ehb_top (
    input  wire logic          clk_i,                    // Core clock, 250 MHz
    input  wire logic          rst_n_i,                  // Sync reset, active low
    input  wire logic          bus_release_req_n_i,      // Bus request from outside master, active low
    input  wire logic          release_block_i,          // Holds off the grant while 1 before the pins float
    input  wire logic          clkout_tristate_sel_i,    // 1: float mem clock out while released
    input  wire logic          wide_mem_port_i,          // 1: wide port, 0: narrow port
    input  wire logic [1:0]    port_clk_src_i,           // Port clock source select
    input  wire logic          ext_mem_clock_in_i,       // External memory clock, sampled
    input  wire logic          mem_busy_i,               // A port transaction is pending
    output logic               bus_release_ack_n_o,      // Bus acknowledge, active low
    output logic               mem_hold_o,               // Stop starting new transactions
    output ehb_pkg::ehb_pin_oe_s pin_oe_n_o,             // Port pin group enables, low = driven
    output logic               mem_clock_out_oe_n_o      // Mem clock out enable, low = driven
);

    ////////////////////////////////////////////////////////////////////////
    // Request synchroniser

    logic req_n_sync;

    ehb_sync #(
        .RESET_VAL (1'b1)
    ) u_req_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (bus_release_req_n_i),
        .q_o     (req_n_sync)
    ); // see RULE15

    ////////////////////////////////////////////////////////////////////////
    // Memory-port clock tick

    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic       ext_clk_d;
    logic       tick;
    logic       next_tick;

    always_comb begin
        next_div_cnt = div_cnt + 3'd1;
        next_tick    = 1'b0;
        unique case (port_clk_src_i)
            `EHB_SRC_DIV4: begin
                next_tick = (div_cnt >= `EHB_DIV4_LAST);
            end
            `EHB_SRC_DIV6: begin
                next_tick = (div_cnt >= `EHB_DIV6_LAST);
            end
            `EHB_SRC_EXT: begin
                next_tick = ext_mem_clock_in_i && !ext_clk_d;
            end
            default: begin
                next_tick = ext_mem_clock_in_i && !ext_clk_d;
            end
        endcase
        if (next_tick || port_clk_src_i == `EHB_SRC_EXT) begin
            next_div_cnt = 3'd0;
        end
    end // see RULE14

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_cnt   <= 3'd0;
            ext_clk_d <= 1'b0;
            tick      <= 1'b0;
        end else begin
            div_cnt   <= next_div_cnt;
            ext_clk_d <= ext_mem_clock_in_i;
            tick      <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake state machine

    ehb_pkg::ehb_state_e  state;
    ehb_pkg::ehb_state_e  next_state;
    logic [2:0]           cnt;
    logic [2:0]           next_cnt;
    logic                 floated;
    logic                 next_floated;
    logic                 clk_float;
    logic                 next_clk_float;
    logic                 next_ack_n;
    logic                 next_hold;
    ehb_pkg::ehb_pin_oe_s next_pin_oe_n;
    logic                 req_lo;

    assign req_lo = !req_n_sync;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_floated   = floated;
        next_clk_float = clk_float;
        next_ack_n     = bus_release_ack_n_o;
        next_hold      = mem_hold_o;
        if (tick && cnt != `EHB_TICK_SAT) begin
            next_cnt = cnt + 3'd1;
        end
        unique case (state)
            ehb_pkg::EHB_IDLE: begin
                next_cnt = 3'd0;
                if (req_lo) begin
                    next_state = ehb_pkg::EHB_DRAIN;
                    next_hold  = 1'b1;
                end
            end
            ehb_pkg::EHB_DRAIN: begin
                if (!req_lo) begin
                    next_state = ehb_pkg::EHB_IDLE;
                    next_hold  = 1'b0;
                end else if (cnt >= `EHB_FLOAT_TICKS && !mem_busy_i && !release_block_i) begin
                    next_state     = ehb_pkg::EHB_FLOAT;
                    next_floated   = 1'b1;                      // see RULE1 see RULE10 see RULE11
                    next_clk_float = clkout_tristate_sel_i;     // see RULE6 see RULE8 see RULE9
                end
            end
            ehb_pkg::EHB_FLOAT: begin
                if (tick) begin
                    next_state = ehb_pkg::EHB_HELD;
                    next_ack_n = 1'b0;                          // see RULE2
                end
            end
            ehb_pkg::EHB_HELD: begin
                next_cnt = 3'd0;
                if (!req_lo) begin
                    next_state = ehb_pkg::EHB_RESUME;           // see RULE3 see RULE16
                end
            end
            ehb_pkg::EHB_RESUME: begin
                if (cnt >= `EHB_RESUME_TICKS) begin
                    next_state     = ehb_pkg::EHB_UNACK;
                    next_floated   = 1'b0;                      // see RULE4
                    next_clk_float = 1'b0;                      // see RULE7
                end
            end
            ehb_pkg::EHB_UNACK: begin
                if (tick) begin
                    next_state = ehb_pkg::EHB_IDLE;
                    next_ack_n = 1'b1;                          // see RULE5
                    next_hold  = 1'b0;
                end
            end
            default: begin
                next_state     = ehb_pkg::EHB_IDLE;
                next_floated   = 1'b0;
                next_clk_float = 1'b0;
                next_ack_n     = 1'b1;
                next_hold      = 1'b0;
            end
        endcase
        next_pin_oe_n = '{
            chip_en_oe_n                    : next_floated,
            byte_en_oe_n                    : next_floated,
            data_oe_n                       : next_floated,
            addr_oe_n                       : next_floated,
            strobe_oe_n                     : next_floated,
            sdram_clock_enable_oe_n         : next_floated || !wide_mem_port_i,
            extra_output_enable_oe_n        : next_floated,
            peripheral_transfer_strobe_oe_n : next_floated
        }; // see RULE12 see RULE13
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state                <= ehb_pkg::EHB_IDLE;
            cnt                  <= 3'd0;
            floated              <= 1'b0;
            clk_float            <= 1'b0;
            bus_release_ack_n_o  <= 1'b1;
            mem_hold_o           <= 1'b0;
            pin_oe_n_o           <= '0;
            mem_clock_out_oe_n_o <= 1'b0;
        end else begin
            state                <= next_state;
            cnt                  <= next_cnt;
            floated              <= next_floated;
            clk_float            <= next_clk_float;
            bus_release_ack_n_o  <= next_ack_n;
            mem_hold_o           <= next_hold;
            pin_oe_n_o           <= next_pin_oe_n;
            mem_clock_out_oe_n_o <= next_clk_float;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [2:0] lo_ticks;
    logic [2:0] hi_ticks;

    // Port clock periods since the synchronised request last changed
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lo_ticks <= 3'd0;
            hi_ticks <= 3'd0;
        end else begin
            lo_ticks <= !req_lo ? 3'd0 : (tick && lo_ticks != `EHB_TICK_SAT) ? lo_ticks + 3'd1 : lo_ticks;
            hi_ticks <= req_lo ? 3'd0 : (tick && hi_ticks != `EHB_TICK_SAT) ? hi_ticks + 3'd1 : hi_ticks;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_float_edge;
        $rose(pin_oe_n_o.data_oe_n);
    endsequence

    sequence s_released;
        !bus_release_ack_n_o && pin_oe_n_o.data_oe_n;
    endsequence

    a_float_late: assert property (s_float_edge |-> lo_ticks >= `EHB_FLOAT_TICKS) // see RULE1
        else $error("port pins floated too early");
    a_ack_after_float: assert property ($fell(bus_release_ack_n_o) |-> $past(pin_oe_n_o.addr_oe_n, 1)) // see RULE2
        else $error("acknowledge fell before pins floated");
    a_resume_window: assert property ($fell(pin_oe_n_o.data_oe_n) |-> hi_ticks >= `EHB_RESUME_TICKS && hi_ticks <= `EHB_RESUME_MAX_E) // see RULE4
        else $error("pins driven outside the resume window");
    a_ack_rise: assert property ($rose(bus_release_ack_n_o) |-> !pin_oe_n_o.strobe_oe_n && !$past(pin_oe_n_o.strobe_oe_n)) // see RULE5
        else $error("acknowledge rose before pins driven");
    a_clk_float: assert property ($rose(mem_clock_out_oe_n_o) |-> clk_float && lo_ticks >= `EHB_FLOAT_TICKS && pin_oe_n_o.data_oe_n) // see RULE6
        else $error("clock output floated wrongly");
    a_clk_drive: assert property ($fell(mem_clock_out_oe_n_o) |-> hi_ticks >= `EHB_RESUME_TICKS && hi_ticks <= `EHB_RESUME_MAX_E) // see RULE7
        else $error("clock output driven outside the resume window");
    a_clk_keep: assert property (s_float_edge |-> $past(clkout_tristate_sel_i, 1) || !mem_clock_out_oe_n_o) // see RULE8
        else $error("clock output floated with float select 0");
    a_clk_tristate: assert property (s_float_edge |-> !$past(clkout_tristate_sel_i, 1) || mem_clock_out_oe_n_o) // see RULE9
        else $error("clock output driven with float select 1");
    a_clk_steady: assert property (s_released ##1 s_released |-> $stable(mem_clock_out_oe_n_o)) // see RULE8
        else $error("clock output enable changed while released");
    a_drain_first: assert property (s_float_edge |-> !$past(mem_busy_i, 1)) // see RULE10
        else $error("pins floated with a transaction pending");
    a_block_grant: assert property (s_float_edge |-> !$past(release_block_i, 1)) // see RULE11
        else $error("bus granted while blocked");
    a_narrow_cke: assert property (!wide_mem_port_i |=> pin_oe_n_o.sdram_clock_enable_oe_n) // see RULE13
        else $error("narrow port drives clock enable");
    a_hold_release: assert property (s_released and req_lo |=> !bus_release_ack_n_o && mem_hold_o ##1 pin_oe_n_o.data_oe_n) // see RULE16
        else $error("bus reclaimed while request low");

endmodule

// ===== tb/ehb_master_model.sv
// Purpose: Outside bus master that borrows the memory port.
// Assumes: Drives its request at the falling edge of clk_i.
// Notes:   linger_i sets how long the request stays low after the grant.
`timescale 1ns/1ps

module ehb_master_model (
    input  wire logic       clk_i,      // Clock
    input  wire logic       go_i,       // Start one request
    input  wire logic       give_up_i,  // Withdraw before the grant
    input  wire logic [7:0] linger_i,   // Cycles held after grant
    input  wire logic       ack_n_i,    // Grant, active low
    output logic            req_n_o,    // Request, active low
    output logic            done_o      // Last request finished
);
    initial begin
        req_n_o = 1'b1;
        done_o  = 1'b1;
        forever begin
            @(negedge clk_i);
            if (go_i) begin
                done_o  = 1'b0;
                req_n_o = 1'b0;
                do @(negedge clk_i); while (ack_n_i !== 1'b0 && !give_up_i);
                if (ack_n_i === 1'b0) begin
                    repeat (linger_i) @(negedge clk_i);
                end
                req_n_o = 1'b1;
                while (ack_n_i !== 1'b1) @(negedge clk_i);
                done_o = 1'b1;
            end
        end
    end
endmodule

// ===== tb/tb_ext_mem_bus_hold_handshake.sv
// Purpose: Self-checking bench of the memory-port bus hold handshake.
// Assumes: Delays are measured in core cycles against port periods E.
// Notes:   External port clock has a period of ten core cycles.
`timescale 1ns/1ps

module tb_ext_mem_bus_hold_handshake;
    logic                 clk_i, rst_n, req_n, blk, sel, wide, ext_ck, busy;
    logic                 ack_n, hold, ck_oe_n, go, give_up, done;
    logic [1:0]           src;
    logic [7:0]           linger, pin_v, pin_held, pin_prev;
    logic                 ck_held, req_prev, ack_prev, ck_prev;
    ehb_pkg::ehb_pin_oe_s pin_oe;
    integer               failures, checks_done, seed, cyc, ext_cnt, e, n_akl;
    integer               t_req, t_rel, t_free, t_flt, t_drv, t_akl, t_akh, t_cf, t_cd;

    assign pin_v = pin_oe;

    ehb_top i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n), .bus_release_req_n_i(req_n), .release_block_i(blk),
        .clkout_tristate_sel_i(sel), .wide_mem_port_i(wide), .port_clk_src_i(src),
        .ext_mem_clock_in_i(ext_ck), .mem_busy_i(busy), .bus_release_ack_n_o(ack_n),
        .mem_hold_o(hold), .pin_oe_n_o(pin_oe), .mem_clock_out_oe_n_o(ck_oe_n)
    );

    ehb_master_model i_master (
        .clk_i(clk_i), .go_i(go), .give_up_i(give_up), .linger_i(linger),
        .ack_n_i(ack_n), .req_n_o(req_n), .done_o(done)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input integer v, input integer lo, input integer hi);
        checks_done++;
        if (v < lo || v > hi) begin
            failures++;
            $display("BAD t=%0t got=%0h exp=%0h..%0h", $time, v, lo, hi);
        end
    endtask

    // Port period in core cycles for each source code
    function automatic integer e_of(input logic [1:0] s);
        case (s)
            2'h1:    e_of = 4;
            2'h2:    e_of = 6;
            default: e_of = 10;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        ext_cnt <= (ext_cnt == 9) ? 0 : ext_cnt + 1;
        ext_ck  <= (ext_cnt < 5);
    end

    // Event times, read once the outputs launched by each rising edge have settled
    always @(posedge clk_i) begin
        #1;
        cyc = cyc + 1;
        if (rst_n) begin
            if (req_prev && !req_n) t_req = cyc;
            if (!req_prev && req_n) t_rel = cyc;
            if (pin_v === 8'hFF && pin_prev !== 8'hFF) t_flt = cyc;
            if (pin_v !== 8'hFF && pin_prev === 8'hFF) t_drv = cyc;
            if (ck_oe_n && !ck_prev) t_cf = cyc;
            if (!ck_oe_n && ck_prev) t_cd = cyc;
            if (blk || busy) t_free = cyc;
            if (ack_prev && !ack_n) begin
                t_akl = cyc;
                n_akl++;
                pin_held = pin_v;
                ck_held = ck_oe_n;
            end
            if (!ack_prev && ack_n) begin
                t_akh = cyc;
                chk_val({7'h0, req_n}, 8'h01);
            end
            if (ack_n === 1'b0 && !req_n) chk_val({7'h0, hold}, 8'h01);
        end
        req_prev = req_n;
        ack_prev = ack_n;
        ck_prev = ck_oe_n;
        pin_prev = pin_v;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic run_hs(input logic [1:0] s, input integer nblk, input integer nbusy, input logic quit);
        integer k;
        integer acks;
        e = e_of(s);
        acks = n_akl;
        @(negedge clk_i);
        src <= s;
        sel <= 1'($random(seed));
        wide <= 1'($random(seed));
        blk <= (nblk > 0);
        busy <= (nbusy > 0);
        linger <= 8'(e + ($random(seed) & 7));
        go <= 1'b1;
        @(negedge clk_i);
        go <= 1'b0;
        t_free = cyc;
        for (k = 1; k <= 40; k++) begin
            if (k == nblk) blk <= 1'b0;
            if (k == nbusy) busy <= 1'b0;
            if (quit && k == 40) give_up <= 1'b1;
            @(negedge clk_i);
        end
        while (!done) @(negedge clk_i);
        // Let a withdrawn request pass the synchroniser before looking at hold
        repeat (4) @(negedge clk_i);
        give_up <= 1'b0;
        blk <= 1'b0;
        chk_val(pin_v, wide ? 8'h00 : 8'h04);
        if (quit) begin
            chk_val(8'(n_akl - acks), 8'h00);
            chk_val({7'h0, hold}, 8'h00);
        end else begin
            chk_rng(t_flt - t_req, 2 * e, 99999);
            chk_rng(t_flt - t_free, 1, 99999);
            chk_rng(t_akl - t_flt, 0, 2 * e);
            chk_rng(t_drv - t_rel, 2 * e, 7 * e);
            chk_rng(t_akh - t_drv, 0, 2 * e);
            chk_val(pin_held, 8'hFF);
            chk_val({7'h0, ck_held}, {7'h0, sel});
            if (sel) begin
                chk_rng(t_cf - t_req, 2 * e, 99999);
                chk_rng(t_cd - t_rel, 2 * e, 7 * e);
            end
        end
    endtask

    initial begin
        #200000;
        failures = failures + 1;
        complete_run;
    end

    initial begin
        seed = 57470;
        failures = 0;
        checks_done = 0;
        cyc = 0;
        ext_cnt = 0;
        n_akl = 0;
        t_req = 0;
        t_rel = 0;
        t_free = 0;
        t_flt = 0;
        t_drv = 0;
        t_akl = 0;
        t_akh = 0;
        t_cf = 0;
        t_cd = 0;
        {rst_n, blk, sel, busy, ext_ck, go, give_up} = 7'h00;
        {req_prev, ack_prev, ck_prev} = 3'h6;
        pin_prev = 8'h00;
        wide = 1'b1;
        src = 2'h1;
        linger = 8'h08;
        repeat (8) @(negedge clk_i);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk_val({5'h0, ack_n, hold, ck_oe_n}, 8'h04);
        chk_val(pin_v, 8'h00);
        run_hs(2'h1, 0, 0, 1'b0);
        for (int i = 0; i < 12; i++) begin
            run_hs(2'(i), $random(seed) & 31, $random(seed) & 31, 1'b0);
        end
        run_hs(2'h2, 99, 0, 1'b1);
        run_hs(2'h2, 0, 3, 1'b0);
        complete_run;
    end
endmodule
